/* rtl/srsc_sensor_reset_standby_control.sv */
// Register bank and exposure timing control for reset, restart, standby and output enable.
//
// Operation
// - Shutter delay N trims integration by N master clocks, N/2 pixel clocks.
// - Shutter delay is inserted after sampling ends, before pixel reset starts.
// - Control bit 0 set enters reset, truncates frame, idles signal interface.
// - In reset all registers return to defaults except the reset bit.
// - Clearing the reset bit resumes normal frame generation.
// - Writing one to bit 1 truncates frame and starts first-row pixel reset.
// - After restart the first exposure is dropped; first valid frame follows the second integration time.
// - Restart bit is write-one trigger and always reads zero.
// - Standby bit 2 places the sensor in low-power state.
// - Bit 3 is plain read/write storage with no effect.
// - Output-disable bit 4 puts all signal interface pins in high impedance.
// - With bit 6 clear, standby pin asserted tri-states the signal interface.
// - With bit 6 set, standby pin no longer affects output enable.
`timescale 1ns/1ps
`default_nettype none

module srsc_sensor_reset_standby_control
  import srsc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 8,
  parameter int ROW_RESET_CYCLES = 8
)(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  input  wire logic        standbyPin,
  output logic             sensorInReset,
  output logic             lowPower,
  output logic             outputEnable,
  output logic             frameValid,
  output logic             sampleStrobe,
  output logic             rowResetStrobe
);

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  logic [15:0]    sensorControl;
  logic [10:0]    shutterDelay;
  logic [15:0]    integrationTime;
  srsc_phase_type phase;
  logic [15:0]    phaseCount;
  logic           firstFrame;

  wire logic        writeControl   = clkEn && regWrite && (regAddr == SRSC_ADDR_SENSOR_CONTROL);
  wire logic        writeShutter   = clkEn && regWrite && (regAddr == SRSC_ADDR_SHUTTER_DELAY);
  wire logic        writeInteg     = clkEn && regWrite && (regAddr == SRSC_ADDR_INTEGRATION_TIME);
  wire logic        resetBit       = sensorControl[SRSC_BIT_RESET];
  wire logic        restartPulse   = writeControl && regWdata[SRSC_BIT_RESTART];
  wire logic [15:0] next_control   = regWdata & SRSC_CONTROL_WRITABLE_MASK;
  wire logic        forceDrive     = sensorControl[SRSC_BIT_FORCE_DRIVE];
  wire logic        outDisable     = sensorControl[SRSC_BIT_OUT_DISABLE];
  wire logic        standbyGate    = standbyPin && !forceDrive;
  wire logic        next_outEnable = !outDisable && !standbyGate;
  wire logic [15:0] integTrimmed   = (integrationTime > {5'h00, shutterDelay})
                                     ? integrationTime - {5'h00, shutterDelay}
                                     : 16'h0001;
  wire logic        next_frameValid;
  wire logic        next_sampleStrobe;
  wire logic        next_rowResetStrobe;

  // Reads return the stored bits; the restart bit is never stored, so it reads zero.
  wire logic [15:0] readMux =
    (regAddr == SRSC_ADDR_SENSOR_CONTROL)   ? sensorControl :
    (regAddr == SRSC_ADDR_SHUTTER_DELAY)    ? {5'h00, shutterDelay} :
    (regAddr == SRSC_ADDR_INTEGRATION_TIME) ? integrationTime :
                                              16'h0000;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sensorControl <= SRSC_CONTROL_RESET_VALUE;
    end
    else if (writeControl)
    begin
      sensorControl <= next_control;
    end
    else if (clkEn && resetBit)
    begin
      // Soft reset clears every other control field but keeps itself.
      sensorControl <= SRSC_CONTROL_RESET_VALUE | 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shutterDelay <= SRSC_SHUTTER_RESET_VALUE;
    end
    else if (clkEn && resetBit)
    begin
      shutterDelay <= SRSC_SHUTTER_RESET_VALUE;
    end
    else if (writeShutter)
    begin
      shutterDelay <= regWdata[10:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      integrationTime <= SRSC_INTEG_RESET_VALUE;
    end
    else if (clkEn && resetBit)
    begin
      integrationTime <= SRSC_INTEG_RESET_VALUE;
    end
    else if (writeInteg)
    begin
      integrationTime <= regWdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Exposure sequencer
  // ---------------------------------------------------------------------------
  // Integration counts master clocks; the shutter delay phase steals its length
  // from integration so the row period stays the same while the delay is below the integration time.
  wire logic phaseDone = (phaseCount == 16'h0000);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase      <= SRSC_PH_RESET_ROW;
      phaseCount <= 16'(ROW_RESET_CYCLES - 1);
      firstFrame <= 1'b1;
    end
    else if (clkEn)
    begin
      if (resetBit || restartPulse)
      begin
        // Truncate the frame and begin resetting the first row.
        phase      <= SRSC_PH_RESET_ROW;
        phaseCount <= 16'(ROW_RESET_CYCLES - 1);
        firstFrame <= 1'b1;
      end
      else if (phaseDone)
      begin
        unique case (phase)
          SRSC_PH_RESET_ROW:
          begin
            phase      <= SRSC_PH_INTEGRATE;
            phaseCount <= integTrimmed - 16'h0001;
          end
          SRSC_PH_INTEGRATE:
          begin
            phase      <= SRSC_PH_SAMPLE;
            phaseCount <= 16'(SAMPLE_CYCLES - 1);
          end
          SRSC_PH_SAMPLE:
          begin
            firstFrame <= 1'b0;
            if (shutterDelay != 11'h000)
            begin
              phase      <= SRSC_PH_DELAY;
              phaseCount <= {5'h00, shutterDelay} - 16'h0001;
            end
            else
            begin
              phase      <= SRSC_PH_RESET_ROW;
              phaseCount <= 16'(ROW_RESET_CYCLES - 1);
            end
          end
          SRSC_PH_DELAY:
          begin
            phase      <= SRSC_PH_RESET_ROW;
            phaseCount <= 16'(ROW_RESET_CYCLES - 1);
          end
        endcase
      end
      else
      begin
        phaseCount <= phaseCount - 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  // Interface idles during reset; the first exposure is dropped and a frame shows after the second full exposure.
  assign next_frameValid     = !resetBit && !restartPulse && !firstFrame &&
                               (phase == SRSC_PH_SAMPLE);
  assign next_sampleStrobe   = !resetBit && (phase == SRSC_PH_SAMPLE) && phaseDone;
  assign next_rowResetStrobe = !resetBit && (phase == SRSC_PH_RESET_ROW);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regRdata <= 16'h0000;
    end
    else if (clkEn && regRead)
    begin
      regRdata <= readMux;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sensorInReset <= 1'b0;
    end
    else if (clkEn)
    begin
      sensorInReset <= resetBit;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lowPower <= 1'b0;
    end
    else if (clkEn)
    begin
      lowPower <= sensorControl[SRSC_BIT_STANDBY];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outputEnable <= 1'b0;
    end
    else if (clkEn)
    begin
      outputEnable <= next_outEnable;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frameValid <= 1'b0;
    end
    else if (clkEn)
    begin
      frameValid <= next_frameValid;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sampleStrobe <= 1'b0;
    end
    else if (clkEn)
    begin
      sampleStrobe <= next_sampleStrobe;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rowResetStrobe <= 1'b0;
    end
    else if (clkEn)
    begin
      rowResetStrobe <= next_rowResetStrobe;
    end
  end

endmodule // srsc_sensor_reset_standby_control

`default_nettype wire

/* rtl/srsc_pkg.sv */
// Package with register map, field positions and reset values of the sensor control block.
package srsc_pkg;

  localparam logic [7:0]  SRSC_ADDR_SHUTTER_DELAY = 8'h0c;
  localparam logic [7:0]  SRSC_ADDR_SENSOR_CONTROL = 8'h0d;
  localparam logic [7:0]  SRSC_ADDR_INTEGRATION_TIME = 8'h09;

  localparam int          SRSC_BIT_RESET       = 0;
  localparam int          SRSC_BIT_RESTART     = 1;
  localparam int          SRSC_BIT_STANDBY     = 2;
  localparam int          SRSC_BIT_SPARE       = 3;
  localparam int          SRSC_BIT_OUT_DISABLE = 4;
  localparam int          SRSC_BIT_FORCE_DRIVE = 6;

  localparam logic [15:0] SRSC_CONTROL_RESET_VALUE   = 16'h0000;
  localparam logic [10:0] SRSC_SHUTTER_RESET_VALUE   = 11'h000;
  localparam logic [15:0] SRSC_INTEG_RESET_VALUE     = 16'h0010;
  localparam logic [15:0] SRSC_CONTROL_WRITABLE_MASK = 16'h005d;

  typedef enum logic [1:0] {
    SRSC_PH_RESET_ROW = 2'b00,
    SRSC_PH_INTEGRATE = 2'b01,
    SRSC_PH_SAMPLE    = 2'b10,
    SRSC_PH_DELAY     = 2'b11
  } srsc_phase_type;

endpackage

/* tb/srsc_sva.sv */
// Checker for the sensor control register bank and output enable.
`timescale 1ns/1ps
`default_nettype none
module srsc_sva
  import srsc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        clkEn,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        standbyPin,
  input wire logic        sensorInReset,
  input wire logic        outputEnable,
  input wire logic        frameValid,
  input wire logic        sampleStrobe,
  input wire logic        rowResetStrobe
);
  logic [15:0] ctl;
  logic        armed;
  wire         wrCtl = clkEn && regWrite && regAddr == 8'h0d;
  wire         rdAny = clkEn && regRead;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Shadow of the control register, cleared to the reset bit during soft reset.
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      ctl <= 16'h0000;
    else if (wrCtl)
      ctl <= regWdata & SRSC_CONTROL_WRITABLE_MASK;
    else if (clkEn && ctl[0])
      ctl <= 16'h0001;
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  a_reset_no_frame: assert property (sensorInReset |-> !frameValid)
    else $error("frame valid during reset");
  a_reset_no_sample: assert property (sensorInReset |-> !sampleStrobe)
    else $error("sampling during reset");
  a_restart_row_reset: assert property (wrCtl && regWdata[1:0] == 2'b10 |-> ##[1:2] rowResetStrobe)
    else $error("restart did not start row reset");
  a_restart_masks_frame: assert property (wrCtl && regWdata[1:0] == 2'b10 |=> !frameValid [*8])
    else $error("frame valid too soon after restart");
  a_control_read_back: assert property (rdAny && regAddr == 8'h0d |=> regRdata == $past(ctl))
    else $error("control read mismatch");
  a_soft_reset_shutter: assert property (rdAny && regAddr == 8'h0c && ctl[0] && $past(ctl[0]) |=> regRdata == 16'h0000)
    else $error("shutter delay kept in reset");
  a_soft_reset_integ: assert property (rdAny && regAddr == 8'h09 && ctl[0] && $past(ctl[0]) |=> regRdata == SRSC_INTEG_RESET_VALUE)
    else $error("integration time kept in reset");
  a_output_enable_rule: assert property (armed && $past(clkEn) |-> outputEnable == (!$past(ctl[4]) && !($past(standbyPin) && !$past(ctl[6]))))
    else $error("output enable mismatch");
endmodule // srsc_sva
bind srsc_sensor_reset_standby_control srsc_sva i_srsc_sva (.core_clk, .arst_n, .clkEn,
  .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .standbyPin, .sensorInReset,
  .outputEnable, .frameValid, .sampleStrobe, .rowResetStrobe);
`default_nettype wire

/* tb/srsc_capture_host.sv */
// Capture host model that counts frames arriving on the driven interface.
`timescale 1ns/1ps
`default_nettype none
module srsc_capture_host
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic frameValid,
  input  wire logic outputEnable,
  output var  int   frames
);
  logic lastValid;
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      {frames, lastValid} <= '0;
    else
    begin
      frames    <= frames + int'(frameValid && outputEnable && !lastValid);
      lastValid <= frameValid && outputEnable;
    end
endmodule // srsc_capture_host
`default_nettype wire

/* tb/sensor_reset_standby_control_bench.sv */
// Self-checking bench for the sensor reset, standby and output control block.
`timescale 1ns/1ps
`default_nettype none
module sensor_reset_standby_control_bench;
  logic        core_clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, standbyPin = 1'b0;
  logic        regWrite = 1'b0, regRead = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000, regRdata, d;
  logic        sensorInReset, lowPower, outputEnable, frameValid, sampleStrobe, rowResetStrobe;
  int          fails = 0, samplesChecked = 0, seed = 32'h8588cf9a, g0, g1, n, f, i, frames;
  srsc_sensor_reset_standby_control i_srsc_sensor_reset_standby_control (.core_clk, .arst_n,
    .clkEn, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .standbyPin, .sensorInReset,
    .lowPower, .outputEnable, .frameValid, .sampleStrobe, .rowResetStrobe);
  srsc_capture_host i_srsc_capture_host (.core_clk, .arst_n, .frameValid, .outputEnable, .frames);
  always #10 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk) {regWrite, regAddr, regWdata} <= {1'b1, a, v};
    @(posedge core_clk) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk) {regRead, regAddr} <= {1'b1, a};
    @(posedge core_clk) regRead <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  // Counts clocks from a sample strobe to the next row reset.
  task automatic gap(output int g);
    g = 0;
    @(posedge sampleStrobe);
    while (rowResetStrobe !== 1'b1 && g < 900)
    begin
      @(posedge core_clk);
      #1 g++;
    end
  endtask
  task automatic testDone;
    $display("Checks %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(8'h0d, 16'h0000);
    rd(8'h0c, 16'h0000);
    rd(8'h09, 16'h0010);
    rd(8'h33, 16'h0000);
    for (i = 0; i < 8; i++)
    begin
      d = 16'($random(seed));
      {d[6], d[4], d[0]} = {i[1], i[0], 1'b0};
      @(posedge core_clk) standbyPin <= i[2];
      wr(8'h0d, d);
      rd(8'h0d, d & 16'h005d);
      chk(16'(lowPower), 16'(d[2]));
      chk(16'(outputEnable), 16'(!d[4] && !(i[2] && !d[6])));
    end
    wr(8'h0c, 16'h07ff);
    wr(8'h0d, 16'h0001);
    rd(8'h0c, 16'h0000);
    rd(8'h0d, 16'h0001);
    chk(16'(sensorInReset), 16'h0001);
    f = frames;
    @(posedge core_clk) standbyPin <= 1'b0;
    wr(8'h0d, 16'h0000);
    repeat (300) @(posedge core_clk);
    chk(16'(frames > f), 16'h0001);
    wr(8'h09, 16'h0040);
    wr(8'h0d, 16'h0002);
    gap(g0);
    n = 1 + {$random(seed)} % 31;
    wr(8'h0c, 16'(n));
    gap(g1);
    gap(g1);
    chk(16'(g1 - g0), 16'(n));
    // A write while the clock enable is low must not land.
    @(posedge core_clk) clkEn <= 1'b0;
    wr(8'h0c, 16'h0123);
    @(posedge core_clk) clkEn <= 1'b1;
    rd(8'h0c, 16'(n));
    wr(8'h0c, 16'h0000);
    testDone;
  end
  initial
  begin
    #1000000;
    fails++;
    testDone;
  end
endmodule // sensor_reset_standby_control_bench
`default_nettype wire
